/* logic/compare_channel.sv */
/*
  One output compare channel: APB register file, mode engine driving the
  compare output pin, fault handling and a masked interrupt.
  Assumes timers, idle request and fault pin are synchronous to pclk.
*/
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "compare_params.svh"

module compare_channel (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Time bases and processor idle
  input  wire logic [`TMR_W-1:0] first_timebase,
  input  wire logic [`TMR_W-1:0] second_timebase,
  input  wire logic              cpu_idle,
  // Pins and interrupt
  input  wire logic              fault_input_pin_n,
  output logic                   compare_output_pin,
  output logic                   pin_owned,
  output logic                   irq
);
  import compare_pkg::*;

  chan_state_t       s_r;
  chan_state_t       s_nxt;
  logic              halt;
  logic              match_a;
  logic              match_b;
  logic              wrap;
  logic              ev_a;
  logic              ev_b;
  logic              ev_w;
  logic              addr_ok;
  logic              wr;
  logic              wr_ctrl;
  logic              cmp_evt;
  logic              flt_evt;
  logic              rise;
  logic              fall;
  logic [31:0]       rd_val;
  logic [`TMR_W-1:0] cmp_a;

  function automatic logic is_pwm(input logic [2:0] m);
    return m[2] & m[1];
  endfunction

  function automatic logic init_level(input logic [2:0] m,
                                      input logic       cur,
                                      input logic       nz);
    case (m)
      `MODE_HIGH_LOW: init_level = 1'b1;
      `MODE_TOGGLE:   init_level = cur;
      `MODE_PWM,
      `MODE_PWMF:     init_level = nz;
      default:        init_level = 1'b0;
    endcase
  endfunction

  assign halt    = s_r.idle_halt & cpu_idle;
  assign cmp_a   = is_pwm(s_r.mode) ? s_r.duty : s_r.primary;
  assign ev_a    = match_a & ~halt;
  assign ev_b    = match_b & ~halt;
  assign ev_w    = wrap & ~halt;
  assign addr_ok = (paddr == `ADDR_CTRL) | (paddr == `ADDR_PRIMARY) |
                   (paddr == `ADDR_SECONDARY) |
                   (paddr == `ADDR_IRQ_STATUS) | (paddr == `ADDR_IRQ_MASK);
  assign wr      = psel & penable & pwrite & addr_ok;
  assign wr_ctrl = wr & (paddr == `ADDR_CTRL);

  compare_match u_match (
    .pclk            (pclk),
    .presetn         (presetn),
    .first_timebase  (first_timebase),
    .second_timebase (second_timebase),
    .timebase_select (s_r.tsel),
    .halt            (halt),
    .cmp_a           (cmp_a),
    .cmp_b           (s_r.secondary),
    .match_a         (match_a),
    .match_b         (match_b),
    .wrap            (wrap)
  );

  always_comb begin
    s_nxt = s_r;
    rd_val = 32'h0;
    case (paddr)
      `ADDR_CTRL: begin
        // Gaps in the control word stay zero
        rd_val[`BIT_IDLE_HALT] = s_r.idle_halt;
        rd_val[`BIT_FAULT]     = s_r.fault;
        rd_val[`BIT_TSEL]      = s_r.tsel;
        rd_val[2:0]            = s_r.mode;
      end
      `ADDR_PRIMARY:    rd_val[`TMR_W-1:0] = s_r.primary;
      `ADDR_SECONDARY:  rd_val[`TMR_W-1:0] = s_r.secondary;
      `ADDR_IRQ_STATUS: rd_val[1:0] = s_r.irq_status;
      `ADDR_IRQ_MASK:   rd_val[1:0] = s_r.irq_mask;
      default:          rd_val = 32'h0;
    endcase
    // Read data captured in setup so it leaves a flip-flop
    if (psel & ~penable & ~pwrite) begin
      s_nxt.prdata = rd_val;
    end

    // Mode engine
    case (s_r.mode)
      `MODE_OFF: s_nxt.pin = 1'b0;
      `MODE_LOW_HIGH: begin
        if (ev_a) begin
          s_nxt.pin = 1'b1;
        end
      end
      `MODE_HIGH_LOW: begin
        if (ev_a) begin
          s_nxt.pin = 1'b0;
        end
      end
      `MODE_TOGGLE: begin
        if (ev_a) begin
          s_nxt.pin = ~s_r.pin;
        end
      end
      `MODE_SINGLE,
      `MODE_CONT: begin
        case (s_r.phase)
          PH_ARM: begin
            if (ev_a) begin
              s_nxt.pin   = 1'b1;
              s_nxt.phase = PH_HIGH;
            end
          end
          PH_HIGH: begin
            if (ev_b) begin
              s_nxt.pin   = 1'b0;
              // One-shot parks, continuous rearms
              s_nxt.phase = s_r.mode[0] ? PH_ARM : PH_DONE;
            end
          end
          default: s_nxt.phase = PH_DONE;
        endcase
      end
      default: begin
        // New duty taken at period start, avoiding mid-period glitches
        if (ev_w) begin
          s_nxt.duty = s_r.secondary;
          s_nxt.pin  = s_r.secondary != '0;
        end else if (ev_a) begin
          s_nxt.pin = 1'b0;
        end
      end
    endcase

    // Fault tracking; fault input has no effect in plain PWM
    if (s_r.mode == `MODE_PWMF) begin
      if (!fault_input_pin_n) begin
        s_nxt.fault = 1'b1;
      end else if (ev_w) begin
        s_nxt.fault = 1'b0;
      end
      if (s_nxt.fault) begin
        s_nxt.pin = 1'b0;
      end
    end else begin
      s_nxt.fault = 1'b0;
    end

    rise    = s_nxt.pin & ~s_r.pin;
    fall    = ~s_nxt.pin & s_r.pin;
    cmp_evt = (rise & ((s_r.mode == `MODE_LOW_HIGH) |
                       (s_r.mode == `MODE_TOGGLE))) |
              (fall & (s_r.mode != `MODE_OFF) & ~is_pwm(s_r.mode) &
                      (s_r.mode != `MODE_LOW_HIGH));
    flt_evt = s_nxt.fault & ~s_r.fault;

    // Hardware set wins over a same-cycle clear
    s_nxt.irq_status = s_r.irq_status & ~((wr &
                       (paddr == `ADDR_IRQ_STATUS)) ? pwdata[1:0] : 2'h0);
    s_nxt.irq_status[`IRQ_CMP] = s_nxt.irq_status[`IRQ_CMP] | cmp_evt;
    s_nxt.irq_status[`IRQ_FLT] = s_nxt.irq_status[`IRQ_FLT] | flt_evt;

    // Register writes; fault bit is not taken from pwdata, cleared by a mode change or by a wrap with the fault input high
    if (wr_ctrl) begin
      s_nxt.idle_halt = pwdata[`BIT_IDLE_HALT];
      s_nxt.tsel      = pwdata[`BIT_TSEL];
      s_nxt.mode      = pwdata[2:0];
      if (pwdata[2:0] != s_r.mode) begin
        // Timer should be stopped by software around this
        s_nxt.pin   = init_level(pwdata[2:0], s_r.pin,
                                 s_r.primary != '0);
        s_nxt.phase = PH_ARM;
        s_nxt.duty  = s_r.primary;
        s_nxt.fault = 1'b0;
      end
    end
    if (wr & (paddr == `ADDR_PRIMARY)) begin
      s_nxt.primary = pwdata[`TMR_W-1:0];
    end
    if (wr & (paddr == `ADDR_SECONDARY)) begin
      s_nxt.secondary = pwdata[`TMR_W-1:0];
    end
    if (wr & (paddr == `ADDR_IRQ_MASK)) begin
      s_nxt.irq_mask = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata             = s_r.prdata;
  assign pready             = 1'b1;
  assign pslverr            = psel & penable & ~addr_ok;
  assign compare_output_pin = s_r.pin;
  assign pin_owned          = s_r.mode != `MODE_OFF;
  assign irq                = |(s_r.irq_status & s_r.irq_mask);

  property p_ctrl_gaps;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `ADDR_CTRL) |=>
      (prdata[31:14] == 18'h0) && (prdata[12:5] == 8'h0);
  endproperty
  a_ctrl_gaps: assert property (p_ctrl_gaps)
    else $error("unimplemented control bits read nonzero");

  property p_halt_freeze;
    @(posedge pclk) disable iff (!presetn)
    (halt && !wr_ctrl) |=> $stable(compare_output_pin);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("output moved while halted in idle");

  property p_fault_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(s_r.fault) |->
      $past(s_r.mode == `MODE_PWMF && !fault_input_pin_n);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault flag set without fault input");

  property p_fault_mode;
    @(posedge pclk) disable iff (!presetn)
    (s_r.mode != `MODE_PWMF) |-> !s_r.fault;
  endproperty
  a_fault_mode: assert property (p_fault_mode)
    else $error("fault flag set outside fault PWM mode");

  property p_fault_off;
    @(posedge pclk) disable iff (!presetn)
    s_r.fault |-> !compare_output_pin;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("output driven during fault");

  property p_set_high;
    @(posedge pclk) disable iff (!presetn)
    (s_r.mode == `MODE_LOW_HIGH && ev_a && !wr_ctrl) |=>
      compare_output_pin;
  endproperty
  a_set_high: assert property (p_set_high)
    else $error("match did not drive output high");

  property p_set_low;
    @(posedge pclk) disable iff (!presetn)
    (s_r.mode == `MODE_HIGH_LOW && ev_a && !wr_ctrl) |=>
      !compare_output_pin;
  endproperty
  a_set_low: assert property (p_set_low)
    else $error("match did not drive output low");

  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
    (s_r.mode == `MODE_TOGGLE && ev_a && !wr_ctrl) |=>
      (compare_output_pin != $past(compare_output_pin));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("match did not toggle output");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    (s_r.mode == `MODE_OFF && !wr_ctrl) |=>
      !compare_output_pin && !$rose(s_r.irq_status[`IRQ_CMP]) ##1 1'b1;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled channel showed activity");

  property p_pwm_no_irq;
    @(posedge pclk) disable iff (!presetn)
    (s_r.mode == `MODE_PWM) |=> !$rose(s_r.irq_status[`IRQ_CMP]);
  endproperty
  a_pwm_no_irq: assert property (p_pwm_no_irq)
    else $error("compare interrupt raised in plain PWM");

  property p_single_done;
    @(posedge pclk) disable iff (!presetn)
    (s_r.mode == `MODE_SINGLE && s_r.phase == PH_DONE && !wr_ctrl) |=>
      !compare_output_pin;
  endproperty
  a_single_done: assert property (p_single_done)
    else $error("single pulse mode produced a second pulse");

endmodule

/* logic/compare_params.svh */
/*
  Offsets, field positions, mode codes and reset values of the output
  compare channel. Included by the package and by the design modules.
*/
`ifndef COMPARE_PARAMS_SVH
`define COMPARE_PARAMS_SVH

`define TMR_W           16
`define ADDR_CTRL       8'h00
`define ADDR_PRIMARY    8'h04
`define ADDR_SECONDARY  8'h08
`define ADDR_IRQ_STATUS 8'h0c
`define ADDR_IRQ_MASK   8'h10

`define BIT_IDLE_HALT   13
`define BIT_FAULT       4
`define BIT_TSEL        3
`define IRQ_CMP         0
`define IRQ_FLT         1

`define MODE_OFF        3'b000
`define MODE_LOW_HIGH   3'b001
`define MODE_HIGH_LOW   3'b010
`define MODE_TOGGLE     3'b011
`define MODE_SINGLE     3'b100
`define MODE_CONT       3'b101
`define MODE_PWM        3'b110
`define MODE_PWMF       3'b111

`define CTRL_RESET      16'h0000
`define IRQ_RESET       2'h0

`endif

/* logic/compare_pkg.sv */
/*
  Types of the output compare channel: pulse phase and state records.
  Assumes compare_params.svh is reachable on the include path.
*/
`include "compare_params.svh"

package compare_pkg;

  typedef enum logic [1:0] {PH_ARM, PH_HIGH, PH_DONE} pulse_phase_t;

  typedef struct packed {
    logic [2:0]        mode;
    logic              tsel;
    logic              idle_halt;
    logic              fault;
    logic [`TMR_W-1:0] primary;
    logic [`TMR_W-1:0] secondary;
    logic [`TMR_W-1:0] duty;
    logic              pin;
    pulse_phase_t      phase;
    logic [1:0]        irq_status;
    logic [1:0]        irq_mask;
    logic [31:0]       prdata;
  } chan_state_t;

  typedef struct packed {
    logic [`TMR_W-1:0] prev;
    logic              match_a;
    logic              match_b;
    logic              wrap;
  } match_state_t;

endpackage

/* logic/compare_match.sv */
/*
  Time base selection and compare match detection for one channel.
  Assumes both timer values are synchronous to pclk.
*/
`timescale 1ns/10ps
`include "compare_params.svh"

module compare_match (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Time bases
  input  wire logic [`TMR_W-1:0] first_timebase,
  input  wire logic [`TMR_W-1:0] second_timebase,
  input  wire logic              timebase_select,
  input  wire logic              halt,
  // Compare values
  input  wire logic [`TMR_W-1:0] cmp_a,
  input  wire logic [`TMR_W-1:0] cmp_b,
  // Events
  output logic                   match_a,
  output logic                   match_b,
  output logic                   wrap
);
  import compare_pkg::*;

  match_state_t      s_r;
  match_state_t      s_nxt;
  logic [`TMR_W-1:0] tval;

  always_comb begin
    tval = timebase_select ? second_timebase : first_timebase;
    s_nxt = s_r;
    // Only a fresh timer value matches, so a held count fires once
    s_nxt.match_a = ~halt & (tval != s_r.prev) & (tval == cmp_a);
    s_nxt.match_b = ~halt & (tval != s_r.prev) & (tval == cmp_b);
    s_nxt.wrap    = ~halt & (tval < s_r.prev);
    if (!halt) begin
      s_nxt.prev = tval;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign match_a = s_r.match_a;
  assign match_b = s_r.match_b;
  assign wrap    = s_r.wrap;

endmodule

/* test/pin_load.sv */
/*
  Load on the compare output: counts rising edges, drives fault input.
  Assumes the bench commands faults, all in the pclk domain.
*/
`timescale 1ns/10ps
module pin_load (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Channel side
  input  wire logic       compare_output_pin,
  output logic            fault_input_pin_n,
  // Bench side
  input  wire logic       fault_cmd,
  output logic [7:0]      rise_cnt
);
  logic last_r;

  // Pulled up; low only while the bench commands a fault
  assign fault_input_pin_n = ~fault_cmd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r   <= 1'b0;
      rise_cnt <= 8'h00;
    end else begin
      last_r <= compare_output_pin;
      if (compare_output_pin && !last_r) begin
        rise_cnt <= rise_cnt + 8'h01;
      end
    end
  end
endmodule

/* test/testbench.sv */
/*
  Self-checking bench of the compare channel: APB tasks, timer steps.
  Assumes compare_params.svh on the include path and the pin load model.
*/
`timescale 1ns/10ps
`include "compare_params.svh"
module testbench;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [`TMR_W-1:0] tmr_a = 16'h0;
  logic [`TMR_W-1:0] tmr_b = 16'h0;
  logic              cpu_idle = 1'b0;
  logic              fault_cmd = 1'b0;
  logic              fault_n;
  logic              pin;
  logic              owned;
  logic              irq;
  logic [7:0]        rises;
  logic [7:0]        base;
  logic [31:0]       rd;
  logic              err;
  int                n_errors = 0;
  int                checks_done = 0;
  int                cycles = 0;
  logic [2:0]        mtab[4] = '{3'b000, 3'b001, 3'b010, 3'b011};
  logic              ini[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic              aft[4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  always #5 pclk = ~pclk;

  compare_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_timebase(tmr_a), .second_timebase(tmr_b), .cpu_idle(cpu_idle),
    .fault_input_pin_n(fault_n), .compare_output_pin(pin),
    .pin_owned(owned), .irq(irq));

  pin_load load_u (.pclk(pclk), .presetn(presetn),
    .compare_output_pin(pin), .fault_input_pin_n(fault_n),
    .fault_cmd(fault_cmd), .rise_cnt(rises));

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask

  // Timers are held still around every control write
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait ends once pready is seen high; the bench timeout catches a stuck slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, rd, e);
  endtask

  // Pin moves two edges after a new timer value; one edge spare
  task automatic step(input logic [15:0] a, input logic [15:0] b);
    @(posedge pclk);
    tmr_a <= a;
    tmr_b <= b;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic drv(input logic idle, input logic flt);
    @(posedge pclk);
    cpu_idle  <= idle;
    fault_cmd <= flt;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", `ADDR_CTRL, 32'h0);
    chk("owned", 32'(owned), 32'h0);
    wr(`ADDR_CTRL, 32'hffffffff);
    rdc("ctrl", `ADDR_CTRL, 32'h200f);
    wr(`ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    $display("test registers done");
    wr(`ADDR_PRIMARY, 32'h10);
    wr(`ADDR_SECONDARY, 32'h20);
    foreach (mtab[i]) begin
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_IRQ_STATUS, 32'h3);
      wr(`ADDR_CTRL, 32'(mtab[i]));
      step(16'h0, 16'h0);
      chk("init", 32'(pin), 32'(ini[i]));
      step(16'h10, 16'h0);
      chk("match", 32'(pin), 32'(aft[i]));
      rdc("stat", `ADDR_IRQ_STATUS, 32'(mtab[i] != 3'b000));
    end
    wr(`ADDR_IRQ_MASK, 32'h1);
    #1;
    chk("irq", 32'(irq), 32'h1);
    wr(`ADDR_IRQ_STATUS, 32'h1);
    #1;
    chk("irq", 32'(irq), 32'h0);
    $display("test modes done");
    wr(`ADDR_CTRL, 32'h000b);
    step(16'h0, 16'h0);
    chk("owned", 32'(owned), 32'h1);
    step(16'h10, 16'h0);
    chk("tsel", 32'(pin), 32'h1);
    step(16'h10, 16'h10);
    chk("tsel", 32'(pin), 32'h0);
    wr(`ADDR_CTRL, 32'h200b);
    drv(1'b1, 1'b0);
    step(16'h10, 16'h0);
    step(16'h10, 16'h10);
    chk("halt", 32'(pin), 32'h0);
    wr(`ADDR_CTRL, 32'h000b);
    step(16'h10, 16'h0);
    step(16'h10, 16'h10);
    chk("run", 32'(pin), 32'h1);
    drv(1'b0, 1'b0);
    $display("test timebase done");
    for (int k = 0; k < 2; k++) begin
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_CTRL, 32'h4 + k);
      step(16'h0, 16'h0);
      chk("pulse", 32'(pin), 32'h0);
      base = rises;
      step(16'h10, 16'h0);
      chk("pulse", 32'(pin), 32'h1);
      step(16'h20, 16'h0);
      chk("pulse", 32'(pin), 32'h0);
      step(16'h10, 16'h0);
      step(16'h20, 16'h0);
      chk("pulses", 32'(rises - base), 32'h1 + k);
    end
    $display("test pulses done");
    wr(`ADDR_CTRL, 32'h0);
    wr(`ADDR_IRQ_STATUS, 32'h3);
    // Start below the duty so the first match is not also a wrap
    step(16'h8, 16'h0);
    wr(`ADDR_CTRL, 32'h6);
    #1;
    chk("pwm", 32'(pin), 32'h1);
    step(16'h10, 16'h0);
    chk("pwm", 32'(pin), 32'h0);
    step(16'h5, 16'h0);
    chk("pwm", 32'(pin), 32'h1);
    drv(1'b0, 1'b1);
    step(16'h11, 16'h0);
    chk("pwm", 32'(pin), 32'h1);
    rdc("ctrl", `ADDR_CTRL, 32'h6);
    rdc("stat", `ADDR_IRQ_STATUS, 32'h0);
    drv(1'b0, 1'b0);
    wr(`ADDR_CTRL, 32'h0);
    wr(`ADDR_CTRL, 32'h7);
    #1;
    chk("pwmf", 32'(pin), 32'h1);
    drv(1'b0, 1'b1);
    step(16'h12, 16'h0);
    chk("fault", 32'(pin), 32'h0);
    rdc("ctrl", `ADDR_CTRL, 32'h17);
    rdc("stat", `ADDR_IRQ_STATUS, 32'h2);
    wr(`ADDR_CTRL, 32'h7);
    drv(1'b0, 1'b0);
    step(16'h13, 16'h0);
    rdc("ctrl", `ADDR_CTRL, 32'h17);
    chk("fault", 32'(pin), 32'h0);
    step(16'h1, 16'h0);
    rdc("ctrl", `ADDR_CTRL, 32'h7);
    $display("test pwm done");
    close_out();
  end
endmodule
